// ### hdl/timer_pkg.sv
// Register map, field layout, reset values and prescale constants of the main timer
package timer_pkg;

    // Word indices; the byte address on the bus is four times the index
    localparam logic [5:0] IDX_FORCE = 6'h0B;
    localparam logic [5:0] IDX_PIN_MASK = 6'h0C;
    localparam logic [5:0] IDX_PIN_DATA = 6'h0D;
    localparam logic [5:0] IDX_COUNT = 6'h0E;
    localparam logic [5:0] IDX_CAPTURE1 = 6'h10;
    localparam logic [5:0] IDX_CAPTURE2 = 6'h12;
    localparam logic [5:0] IDX_CAPTURE3 = 6'h14;
    localparam logic [5:0] IDX_COMPARE1 = 6'h16;
    localparam logic [5:0] IDX_COMPARE2 = 6'h18;
    localparam logic [5:0] IDX_COMPARE3 = 6'h1A;
    localparam logic [5:0] IDX_COMPARE4 = 6'h1C;
    localparam logic [5:0] IDX_SHARED = 6'h1E;
    localparam logic [5:0] IDX_ACTION = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h22;
    localparam logic [5:0] IDX_STATUS = 6'h23;
    localparam logic [5:0] IDX_CONFIG = 6'h24;

    // Channel and pin positions: channel one at bit 7 down to channel five at bit 3
    localparam int CH_ONE = 7;
    localparam int CH_LO = 3;
    localparam int CH_SHARED = 3;
    localparam int NUM_CAPTURE = 4;

    // Status layout
    localparam int STATUS_W = 9;
    localparam int ST_OVERFLOW = 8;
    localparam int ST_CAPTURE1 = 2;
    localparam int ST_CAPTURE2 = 1;
    localparam int ST_CAPTURE3 = 0;

    // Configuration layout
    localparam int CFG_PRESCALE_LO = 0;
    localparam int CFG_SHARED_CAPTURE = 2;

    // Reset values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
    localparam logic [7:0] PIN_FIELD_RESET = 8'h00;
    localparam logic [7:0] ACTION_RESET = 8'h00;
    localparam logic [2:0] CONFIG_RESET = 3'h0;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 9'h000;

    // Compare output actions
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // Prescale: last value of the divider count for 1, 4, 8 and 16 cycles per count
    localparam logic [1:0] PRESCALE_1 = 2'h0;
    localparam logic [1:0] PRESCALE_4 = 2'h1;
    localparam logic [1:0] PRESCALE_8 = 2'h2;
    localparam logic [1:0] PRESCALE_16 = 2'h3;
    localparam logic [3:0] LAST_1 = 4'h0;
    localparam logic [3:0] LAST_4 = 4'h3;
    localparam logic [3:0] LAST_8 = 4'h7;
    localparam logic [3:0] LAST_16 = 4'hF;

    function automatic logic [3:0] prescale_last(input logic [1:0] sel);
        case (sel)
            PRESCALE_1: prescale_last = LAST_1;
            PRESCALE_4: prescale_last = LAST_4;
            PRESCALE_8: prescale_last = LAST_8;
            default: prescale_last = LAST_16;
        endcase
    endfunction

endpackage

// ### hdl/prescale_divider.sv
// Programmable prescaler giving the counter's one-cycle advance enable
`timescale 1ns/1ns
module prescale_divider import timer_pkg::*; (
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic [1:0] prescale_select, // Cycles per count: 1, 4, 8, 16
    output logic tick // One-cycle advance enable
);

    logic [3:0] div_count;
    logic [1:0] last_select;

    // A change of rate restarts the divider and drops that cycle's tick, so the first new count lasts one new period plus a cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_count <= LAST_1;
            last_select <= PRESCALE_1;
        end else begin
            last_select <= prescale_select;
            if (prescale_select != last_select || div_count >= prescale_last(prescale_select))
                div_count <= LAST_1;
            else
                div_count <= div_count + 4'h1;
        end
    end

    assign tick = (prescale_select == last_select) &&
                  (div_count == prescale_last(prescale_select));

    a_tick_terminal: assert property (@(posedge sys_clk) disable iff (!resetn)
        tick && prescale_select == PRESCALE_4 |=> !tick [*3] ##1 1'b1)
        else $error("prescaler ticked early in divide by four");

    a_divide_one: assert property (@(posedge sys_clk) disable iff (!resetn)
        (prescale_select == PRESCALE_1 && last_select == PRESCALE_1) |-> tick)
        else $error("prescaler missed a tick in divide by one");

endmodule // prescale_divider

// ### hdl/main_timer_force_compare.sv
// Main timer: counter, compare and capture channels, forced compare and pin control
//
// Behaviour
// - Free-running 16-bit counter advances once per 1, 4, 8 or 16 cycles.
// - Counter wrap from maximum to zero raises a sticky overflow flag.
// - Three capture, four compare, and one shared capture-or-compare channel.
// - Writing one to a force bit performs that channel's output action at once.
// - Set mask bits 7 to 3 let compare one control matching pins.
// - Low three bits of force, mask and data registers read zero.
// - Reset clears the compare-one mask and data registers.
// - Compare-one match drives each masked pin with its data bit.
// - Channels two to five: 00 off, 01 toggle, 10 clear, 11 set.
// - Counter equal to a compare value sets that channel's flag.
// - Counter resets to zero and ignores software writes.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
module main_timer_force_compare import timer_pkg::*; (
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic [7:0] avs_address, // Avalon byte address
    input wire logic avs_read, // Avalon read request
    input wire logic avs_write, // Avalon write request
    input wire logic [31:0] avs_writedata, // Avalon write data
    input wire logic [3:0] avs_byteenable, // Avalon byte enables
    output logic [31:0] avs_readdata, // Avalon read data, registered
    output logic avs_waitrequest, // Avalon wait request
    input wire logic [NUM_CAPTURE-1:0] capture_in, // Capture inputs, rising edge
    output logic [7:3] compare_pin, // Port pin values driven by the timer
    output logic [7:3] compare_pin_en, // High where the timer owns the pin
    output logic irq // Level interrupt, unmasked status set
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic ack;
    logic [5:0] idx;
    logic bus_first;
    logic done_wr;
    logic done_rd;
    logic [31:0] next_readdata;
    logic [STATUS_W-1:0] clear_bits;

    assign idx = avs_address[7:2];
    assign bus_first = (avs_read || avs_write) && !ack;
    assign avs_waitrequest = bus_first;
    assign done_wr = avs_write && ack;
    assign done_rd = avs_read && ack;

    // One wait cycle: the first cycle fetches read data, the second completes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            ack <= 1'b0;
        else
            ack <= bus_first;
    end

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = old;
        if (be[0])
            merge16[7:0] = wd[7:0];
        if (be[1])
            merge16[15:8] = wd[15:8];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers

    logic [7:3] pin_mask;
    logic [7:3] pin_data;
    logic [7:0] action;
    logic [1:0] prescale_select;
    logic shared_capture;
    logic [STATUS_W-1:0] irq_mask;
    logic [7:3] force_bits;
    logic low_write;
    logic [15:0] mask_merged;

    assign low_write = done_wr && avs_byteenable[0];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_mask <= PIN_FIELD_RESET[7:3];
            pin_data <= PIN_FIELD_RESET[7:3];
        end else if (low_write && idx == IDX_PIN_MASK) begin
            pin_mask <= avs_writedata[7:3];
        end else if (low_write && idx == IDX_PIN_DATA) begin
            pin_data <= avs_writedata[7:3];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            action <= ACTION_RESET;
            prescale_select <= CONFIG_RESET[1:0];
            shared_capture <= CONFIG_RESET[CFG_SHARED_CAPTURE];
        end else if (low_write && idx == IDX_ACTION) begin
            action <= avs_writedata[7:0];
        end else if (low_write && idx == IDX_CONFIG) begin
            prescale_select <= avs_writedata[CFG_PRESCALE_LO +: 2];
            shared_capture <= avs_writedata[CFG_SHARED_CAPTURE];
        end
    end

    // The merge helper works on 16 bits; the mask keeps only the status-wide part
    assign mask_merged = merge16({7'h00, irq_mask}, avs_writedata, avs_byteenable);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            irq_mask <= STATUS_RESET;
        else if (done_wr && idx == IDX_IRQ_MASK)
            irq_mask <= mask_merged[STATUS_W-1:0];
    end

    // Force bits live for the completing write edge only; nothing is stored
    assign force_bits = (low_write && idx == IDX_FORCE) ? avs_writedata[7:3] : 5'h00;

    function automatic logic [1:0] action_of(input logic [7:0] act, input int ch);
        action_of = act[2*ch-6 +: 2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Counter and compare channels

    logic tick;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [15:0] compare_value [7:3];
    logic [7:3] match;

    prescale_divider u_prescale (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .prescale_select(prescale_select),
        .tick(tick)
    );

    assign next_count = count + COUNT_STEP;

    // Software writes to the counter index fall through without effect
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            count <= COUNT_RESET;
        else if (tick)
            count <= next_count;
    end

    // The match is judged on the value the counter takes at this tick
    always_comb begin
        for (int ch = CH_LO; ch <= CH_ONE; ch++)
            match[ch] = tick && (next_count == compare_value[ch]);
        if (shared_capture)
            match[CH_SHARED] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capture channels; the shared register takes the fourth capture

    logic [NUM_CAPTURE-1:0] capture_prev;
    logic [NUM_CAPTURE-1:0] rise;
    logic [15:0] capture_value [0:2];

    assign rise = capture_in & ~capture_prev;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            capture_prev <= '0;
        else
            capture_prev <= capture_in;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++)
                capture_value[i] <= COUNT_RESET;
        end else begin
            for (int i = 0; i < 3; i++)
                if (rise[i])
                    capture_value[i] <= count;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int ch = CH_LO; ch <= CH_ONE; ch++)
                compare_value[ch] <= COMPARE_RESET;
        end else begin
            if (done_wr) begin
                if (idx == IDX_COMPARE1)
                    compare_value[7] <= merge16(compare_value[7], avs_writedata, avs_byteenable);
                if (idx == IDX_COMPARE2)
                    compare_value[6] <= merge16(compare_value[6], avs_writedata, avs_byteenable);
                if (idx == IDX_COMPARE3)
                    compare_value[5] <= merge16(compare_value[5], avs_writedata, avs_byteenable);
                if (idx == IDX_COMPARE4)
                    compare_value[4] <= merge16(compare_value[4], avs_writedata, avs_byteenable);
                // In capture mode the shared register ignores writes
                if (idx == IDX_SHARED && !shared_capture)
                    compare_value[3] <= merge16(compare_value[3], avs_writedata, avs_byteenable);
            end
            if (shared_capture && rise[3])
                compare_value[CH_SHARED] <= count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin actions; compare one is applied last so it wins on a shared pin

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            compare_pin <= PIN_FIELD_RESET[7:3];
        end else begin
            for (int ch = CH_LO; ch < CH_ONE; ch++) begin
                if (match[ch] || force_bits[ch]) begin
                    case (action_of(action, ch))
                        ACT_TOGGLE: compare_pin[ch] <= !compare_pin[ch];
                        ACT_CLEAR: compare_pin[ch] <= 1'b0;
                        ACT_SET: compare_pin[ch] <= 1'b1;
                        default: compare_pin[ch] <= compare_pin[ch];
                    endcase
                end
            end
            if (match[CH_ONE] || force_bits[CH_ONE]) begin
                for (int b = CH_LO; b <= CH_ONE; b++)
                    if (pin_mask[b])
                        compare_pin[b] <= pin_data[b];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            compare_pin_en <= PIN_FIELD_RESET[7:3];
        end else begin
            compare_pin_en[CH_ONE] <= pin_mask[CH_ONE];
            for (int ch = CH_LO; ch < CH_ONE; ch++)
                compare_pin_en[ch] <= pin_mask[ch] || (action_of(action, ch) != ACT_OFF);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags and interrupt; forced actions never reach these flags

    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] set_bits;

    always_comb begin
        set_bits = '0;
        set_bits[ST_OVERFLOW] = tick && (count == COUNT_MAX);
        set_bits[7:3] = match;
        if (shared_capture)
            set_bits[CH_SHARED] = rise[3];
        set_bits[ST_CAPTURE1] = rise[0];
        set_bits[ST_CAPTURE2] = rise[1];
        set_bits[ST_CAPTURE3] = rise[2];
    end

    // Only bits that the read reported are cleared, and a new event wins over the clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            status <= STATUS_RESET;
        else if (done_rd && idx == IDX_STATUS)
            status <= (status & ~clear_bits) | set_bits;
        else
            status <= status | set_bits;
    end

    assign irq = |(status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (idx)
            IDX_PIN_MASK: next_readdata[7:3] = pin_mask;
            IDX_PIN_DATA: next_readdata[7:3] = pin_data;
            IDX_COUNT: next_readdata[15:0] = count;
            IDX_CAPTURE1: next_readdata[15:0] = capture_value[0];
            IDX_CAPTURE2: next_readdata[15:0] = capture_value[1];
            IDX_CAPTURE3: next_readdata[15:0] = capture_value[2];
            IDX_COMPARE1: next_readdata[15:0] = compare_value[7];
            IDX_COMPARE2: next_readdata[15:0] = compare_value[6];
            IDX_COMPARE3: next_readdata[15:0] = compare_value[5];
            IDX_COMPARE4: next_readdata[15:0] = compare_value[4];
            IDX_SHARED: next_readdata[15:0] = compare_value[3];
            IDX_ACTION: next_readdata[7:0] = action;
            IDX_IRQ_MASK: next_readdata[STATUS_W-1:0] = irq_mask;
            IDX_STATUS: next_readdata[STATUS_W-1:0] = status;
            IDX_CONFIG: next_readdata[2:0] = {shared_capture, prescale_select};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
            clear_bits <= STATUS_RESET;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_readdata;
            clear_bits <= (idx == IDX_STATUS) ? status : STATUS_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_read_low_field;
        avs_read && !ack && (idx == IDX_FORCE || idx == IDX_PIN_MASK || idx == IDX_PIN_DATA);
    endsequence

    sequence s_force_set_two;
        force_bits[6] && !match[6] && action_of(action, 6) == ACT_SET
            && !force_bits[CH_ONE] && !match[CH_ONE];
    endsequence

    // The divider ticks during reset too; the release edge itself still holds the count
    a_count_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        resetn && tick |=> count == $past(next_count))
        else $error("counter did not advance on tick");

    a_count_readonly: assert property (@(posedge sys_clk) disable iff (!resetn)
        !tick |=> count == $past(count))
        else $error("counter moved without tick");

    a_overflow_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
        tick && count == COUNT_MAX |=> status[ST_OVERFLOW] && count == COUNT_RESET)
        else $error("wrap did not raise overflow");

    a_capture_load: assert property (@(posedge sys_clk) disable iff (!resetn)
        rise[0] |=> capture_value[0] == $past(count) && status[ST_CAPTURE1])
        else $error("capture one missed its edge");

    a_force_action: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_force_set_two |=> compare_pin[6] ##1 compare_pin_en[6])
        else $error("forced set on channel two failed");

    a_force_no_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
        (s_force_set_two and !status[6]) |=> !status[6])
        else $error("forced compare raised a flag");

    a_masked_data: assert property (@(posedge sys_clk) disable iff (!resetn)
        (match[CH_ONE] || force_bits[CH_ONE]) && pin_mask[5]
            |=> compare_pin[5] == $past(pin_data[5]))
        else $error("compare one did not drive masked pin");

    a_low_bits_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_read_low_field |=> avs_readdata[2:0] == 3'h0 && !avs_waitrequest)
        else $error("unimplemented low bits read nonzero");

    a_match_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
        match[6] |=> status[6] && irq == $past(irq_mask[6]) || $past(irq))
        else $error("compare match did not set flag");

    a_reset_clear: assert property (@(posedge sys_clk)
        !resetn |=> pin_mask == 5'h00 && pin_data == 5'h00)
        else $error("mask or data not cleared by reset");

endmodule // main_timer_force_compare

// ### tb/main_timer_force_compare_bench.sv
// Self-checking bench for the main timer: bus, forced and matched compares, prescale, overflow
`timescale 1ns/1ns
module main_timer_force_compare_bench import timer_pkg::*;;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [NUM_CAPTURE-1:0] capture_in = 4'h0;
    logic [7:3] compare_pin;
    logic [7:3] compare_pin_en;
    logic irq;
    int miscompares = 0;
    int checks_done = 0;
    int lt;
    logic [31:0] rv;
    logic [7:3] pins_m = 5'h00;

    main_timer_force_compare main_timer_force_compare_inst (.sys_clk(sys_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .capture_in(capture_in), .compare_pin(compare_pin),
        .compare_pin_en(compare_pin_en), .irq(irq));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low; lt keeps the edge that loads readdata
    task automatic bus(input logic [5:0] idx, input logic w, input logic [31:0] wd,
                       output logic [31:0] rdv);
        int n;
        n = 0;
        avs_address <= {idx, 2'h0};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= wd;
        do begin
            @(posedge sys_clk);
            n++;
            if (n == 1) lt = $time;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            complete_run();
        end
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(idx, 1'b1, wd, dummy);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] rdv);
        bus(idx, 1'b0, 32'h0, rdv);
    endtask

    // Channels two to five act first; channel one then overrides its masked pins
    function automatic logic [7:3] act_pins(input logic [7:3] sel, input logic [7:0] act,
                                            input logic [7:3] msk, input logic [7:3] dat,
                                            input logic [7:3] cur);
        logic [7:3] r;
        logic [1:0] c;
        r = cur;
        for (int p = 3; p < 7; p++) begin
            c = act[2*(p-3) +: 2];
            if (sel[p] && c == ACT_TOGGLE) r[p] = ~r[p];
            if (sel[p] && c == ACT_CLEAR) r[p] = 1'b0;
            if (sel[p] && c == ACT_SET) r[p] = 1'b1;
        end
        if (sel[7]) r = (r & ~msk) | (dat & msk);
        return r;
    endfunction

    function automatic logic [7:3] en_model(input logic [7:3] msk, input logic [7:0] act);
        logic [7:3] e;
        e[7] = msk[7];
        for (int p = 3; p < 7; p++) e[p] = msk[p] | (act[2*(p-3) +: 2] != ACT_OFF);
        return e;
    endfunction

    task automatic pin_check(input logic [7:0] a, input logic [7:0] m);
        chk({27'h0, compare_pin}, {27'h0, pins_m}, "pin values");
        chk({27'h0, compare_pin_en}, {27'h0, en_model(m[7:3], a)}, "pin ownership");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] m;
        logic [7:0] d;
        logic [7:0] a;
        logic [7:0] f;
        logic [15:0] c1;
        logic [15:0] t;
        logic [5:0] ci[5];
        logic [5:0] cp[4];
        logic ok;
        int l1;
        int dv;
        int i;
        ci = '{IDX_COMPARE1, IDX_COMPARE2, IDX_COMPARE3, IDX_COMPARE4, IDX_SHARED};
        cp = '{IDX_CAPTURE1, IDX_CAPTURE2, IDX_CAPTURE3, IDX_SHARED};
        void'($urandom(9));
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(IDX_COUNT, rv);
        chk({31'h0, rv[15:0] < 16'h0010}, 32'h1, "count after reset");
        rd(IDX_PIN_MASK, rv);
        chk(rv, 32'h0, "mask reset");
        rd(IDX_PIN_DATA, rv);
        chk(rv, 32'h0, "data reset");
        wr(IDX_FORCE, 32'h07);
        rd(IDX_FORCE, rv);
        chk(rv, 32'h0, "force readback");
        chk({27'h0, compare_pin}, 32'h0, "low force bits act");
        rd(6'h3F, rv);
        chk(rv, 32'h0, "unmapped read");
        $display("test reset finished");
        // All interrupts enabled, so a flag raised by a force would show on irq
        wr(IDX_IRQ_MASK, 32'h1FF);
        // Every action code on every channel, random force, mask and data
        for (int k = 0; k < 4; k++) begin
            a = {4{k[1:0]}};
            m = 8'($urandom) | 8'h07;
            d = 8'($urandom);
            f = 8'($urandom) & 8'hF8;
            wr(IDX_ACTION, {24'h0, a});
            wr(IDX_PIN_MASK, {24'h0, m});
            rd(IDX_PIN_MASK, rv);
            chk(rv, {24'h0, m & 8'hF8}, "mask readback");
            wr(IDX_PIN_DATA, {24'h0, d});
            rd(IDX_PIN_DATA, rv);
            chk(rv, {24'h0, d & 8'hF8}, "data readback");
            wr(IDX_FORCE, {24'h0, f});
            pins_m = act_pins(f[7:3], a, m[7:3], d[7:3], pins_m);
            pin_check(a, m);
        end
        f = 8'h40;
        wr(IDX_FORCE, {24'h0, f});
        pins_m = act_pins(f[7:3], a, m[7:3], d[7:3], pins_m);
        pin_check(a, m);
        rd(IDX_STATUS, rv);
        chk(rv, 32'h0, "force set a flag");
        chk({31'h0, irq}, 32'h0, "force raised irq");
        $display("test force finished");
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(IDX_PIN_MASK, rv);
        chk(rv, 32'h0, "mask after reset");
        rd(IDX_PIN_DATA, rv);
        chk(rv, 32'h0, "data after reset");
        pins_m = 5'h00;
        pin_check(8'h00, 8'h00);
        $display("test second reset finished");
        rd(IDX_COUNT, rv);
        t = rv[15:0] + 16'h012C;
        foreach (ci[j]) wr(ci[j], {16'h0, t});
        a = 8'($urandom);
        m = 8'($urandom) & 8'hF8;
        d = 8'($urandom) & 8'hF8;
        wr(IDX_ACTION, {24'h0, a});
        wr(IDX_PIN_MASK, {24'h0, m});
        wr(IDX_PIN_DATA, {24'h0, d});
        repeat (350) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0, "masked irq");
        pins_m = act_pins(5'h1F, a, m[7:3], d[7:3], pins_m);
        pin_check(a, m);
        rd(IDX_STATUS, rv);
        chk(rv, 32'h0F8, "compare flags");
        rd(IDX_STATUS, rv);
        chk(rv, 32'h0, "status cleared by read");
        $display("test compare finished");
        wr(IDX_CONFIG, 32'h4);
        rd(IDX_COUNT, rv);
        c1 = rv[15:0];
        capture_in <= 4'hF;
        @(posedge sys_clk);
        l1 = $time;
        capture_in <= 4'h0;
        t = c1 + 16'((l1 - lt) / 10);
        // Shared register is in capture mode, so this write must leave it alone
        wr(IDX_SHARED, 32'h5555);
        foreach (cp[j]) begin
            rd(cp[j], rv);
            chk(rv, {16'h0, t}, "capture value");
        end
        rd(IDX_STATUS, rv);
        chk(rv, 32'h00F, "capture flags");
        $display("test capture finished");
        for (int p = 0; p < 4; p++) begin
            dv = (p == 0) ? 1 : (4 << (p - 1));
            wr(IDX_CONFIG, p);
            rd(IDX_COUNT, rv);
            c1 = rv[15:0];
            l1 = lt;
            wr(IDX_COUNT, 32'h1234);
            repeat (40) @(posedge sys_clk);
            rd(IDX_COUNT, rv);
            t = rv[15:0] - c1;
            ok = (t >= (lt - l1) / 10 / dv) && (t <= (lt - l1) / 10 / dv + 1);
            chk({31'h0, ok}, 32'h1, "count rate");
        end
        wr(IDX_CONFIG, 32'h0);
        $display("test prescale finished");
        wr(IDX_IRQ_MASK, 32'h100);
        i = 0;
        while (irq !== 1'b1 && i < 70000) begin
            @(posedge sys_clk);
            i++;
        end
        if (i >= 70000) begin
            miscompares++;
            complete_run();
        end
        rd(IDX_STATUS, rv);
        chk(rv, 32'h100, "overflow flag");
        rd(IDX_COUNT, rv);
        chk({31'h0, rv[15:0] < 16'h0040}, 32'h1, "count after wrap");
        chk({31'h0, irq}, 32'h0, "irq after clear");
        $display("test overflow finished");
        complete_run();
    end
endmodule // main_timer_force_compare_bench
